// file: core/codec_power_ctrl.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
// Behaviour
// RULE_01: right adc format encodes four sample types
// RULE_02: left adc format uses same encodings
// RULE_03: host writes zero to reserved bits
// RULE_04: format register zero, frozen while pins low
// RULE_05: power register bit layout at index 27
// RULE_06: resource free keeps idle digital resources lent
// RULE_07: dac mix off holds register three
// RULE_08: dac two off stops requests, holds ten
// RULE_09: dac two restarts after six frame syncs
// RULE_10: dac one off stops requests, holds nine
// RULE_11: dac one restarts after six frame syncs
// RULE_12: analog off clears registers four to ten; code clears only the low half of register eight
// RULE_13: analog on lets each path follow enable
// RULE_14: headphone power follows its enable bit
// RULE_15: analog mix off clears four to eight-half
// RULE_16: adc off stops after frame, restarts delayed
// RULE_17: power register 00c0, frozen while pins low
// RULE_18: lock mode needs both adc enables equal
// RULE_19: blocked register reads default, drops writes
module codec_power_ctrl
  import codec_power_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic power_down_pin_n,
  input wire logic converter_power_status,
  input wire logic frame_sync,
  input wire logic conversion_clock,
  output logic resource_free,
  output logic analog_power,
  output logic dac_one_analog_power,
  output logic dac_two_analog_power,
  output logic adc_left_analog_power,
  output logic adc_right_analog_power,
  output logic dac_to_dac_mix_power,
  output logic analog_mix_power,
  output logic headphone_power,
  output logic [NUM_CH-1:0] digital_power,
  output logic [NUM_CH-1:0] sample_request,
  output logic [NUM_CH-1:0] conversion_running,
  output logic [1:0] adc_left_format,
  output logic [1:0] adc_right_format
);

  localparam int unsigned DEP_DEPTH = 8;
  localparam int unsigned DEP_AW = $clog2(DEP_DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] power;
    logic [15:0] format;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic fs_prev;
    logic conversion_clock_prev;
    logic ana;
    logic dac1_ana;
    logic dac2_ana;
    logic adcl_ana;
    logic adcr_ana;
    logic ddm;
    logic aam;
    logic hp;
    logic rfree;
    logic [NUM_CH-1:0] dig;
  } ctrl_state_type;

  ctrl_state_type s_q, s_d;

  logic [5:0] index;
  logic mapped;
  logic is_dep;
  logic wr_fire;
  logic [15:0] wdata16;
  logic [DEP_AW-1:0] dep_wr_index;
  logic [DEP_AW-1:0] dep_rd_index;
  logic [15:0] dep_rdata;
  logic fs_rise;
  logic conversion_clock_rise;
  logic hold_power;
  logic hold_format;
  logic en_ana;
  logic en_dac1;
  logic en_dac2;
  logic en_adcl;
  logic en_adcr;
  logic en_ddm;
  logic en_aam;
  logic [NUM_CH-1:0] chan_enable;
  logic [NUM_CH-1:0] chan_req;
  logic [NUM_CH-1:0] chan_run;
  logic [DEP_DEPTH-1:0][15:0] hold_mask;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------

  // word index from the byte address
  assign index = paddr[ADDR_SHIFT +: 6];
  assign is_dep = (index >= IDX_DEP_FIRST) && (index <= IDX_DEP_LAST);
  assign mapped = is_dep || (index == IDX_ADC_FORMAT) || (index == IDX_POWER);

  // a write takes effect on the edge that completes the access
  assign wr_fire = psel && penable && pwrite && s_q.pready && mapped;
  assign wdata16 = pwdata[15:0];
  assign dep_wr_index = DEP_AW'(index - IDX_DEP_FIRST);
  assign dep_rd_index = DEP_AW'(index - IDX_DEP_FIRST);

  // ----------------------------------------------------------------
  // pin edges and enable fields
  // ----------------------------------------------------------------

  // pins are synchronous, so a previous-value flop finds the edge
  assign fs_rise = frame_sync && !s_q.fs_prev;
  assign conversion_clock_rise = conversion_clock && !s_q.conversion_clock_prev;

  // register freeze conditions
  assign hold_format = !reset_pin_n || !power_down_pin_n; // RULE_04
  assign hold_power = hold_format || converter_power_status; // RULE_17

  // individual enable bits
  assign en_ana = s_q.power[BIT_ANALOG]; // RULE_05
  assign en_dac1 = s_q.power[BIT_DAC_ONE];
  assign en_dac2 = s_q.power[BIT_DAC_TWO];
  assign en_adcl = s_q.power[BIT_ADC_LEFT];
  assign en_adcr = s_q.power[BIT_ADC_RIGHT];
  assign en_ddm = s_q.power[BIT_DAC_MIX];
  assign en_aam = s_q.power[BIT_ANALOG_MIX];

  // channel enables for the startup sequencers
  always_comb begin
    chan_enable = '0;
    chan_enable[CH_DAC_ONE] = en_dac1;
    chan_enable[CH_DAC_TWO] = en_dac2;
    chan_enable[CH_ADC_LEFT] = en_adcl;
    chan_enable[CH_ADC_RIGHT] = en_adcr;
  end

  // ----------------------------------------------------------------
  // dependent register hold masks
  // ----------------------------------------------------------------

  // which bits of each dependent register are pinned at default
  always_comb begin
    hold_mask = '0;
    if (!en_ddm) begin
      hold_mask[IDX_MIX_DAC - IDX_DEP_FIRST] = '1; // RULE_07
    end
    for (int i = 0; i < DEP_DEPTH; i++) begin
      if ((i >= IDX_ANA_FIRST - IDX_DEP_FIRST) && (i <= IDX_ANA_LAST - IDX_DEP_FIRST)
          && (!en_ana || !en_aam)) begin
        hold_mask[i] = '1; // RULE_12 RULE_15
      end
    end
    if (!en_ana || !en_aam) begin
      hold_mask[IDX_HALF - IDX_DEP_FIRST] = HALF_MASK; // RULE_12 RULE_15
    end
    if (!en_ana || !en_dac1) begin
      hold_mask[IDX_DAC1_LEVEL - IDX_DEP_FIRST] = '1; // RULE_10 RULE_12
    end
    if (!en_ana || !en_dac2) begin
      hold_mask[IDX_DAC2_LEVEL - IDX_DEP_FIRST] = '1; // RULE_08 RULE_12
    end
  end

  // ----------------------------------------------------------------
  // dependent register store
  // ----------------------------------------------------------------

  // output-level and mix registers, with registered read data
  dependent_regs #(
    .DEPTH(DEP_DEPTH),
    .WIDTH(16)
  ) u_dep (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_fire && is_dep),
    .wr_index(dep_wr_index),
    .wr_data(wdata16),
    .rd_index(dep_rd_index),
    .hold_mask(hold_mask),
    .rd_data(dep_rdata)
  );

  // ----------------------------------------------------------------
  // channel startup sequencers
  // ----------------------------------------------------------------

  // one sequencer per channel; adc requests stop at the frame boundary
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    channel_start #(
      .IS_ADC(c == CH_ADC_LEFT || c == CH_ADC_RIGHT)
    ) u_start (
      .clk(clk),
      .rst(rst),
      .enable(chan_enable[c]),
      .fs_rise(fs_rise),
      .conversion_clock_rise(conversion_clock_rise),
      .request(chan_req[c]),
      .running(chan_run[c])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // registers, bus answer and power outputs
  always_comb begin
    s_d = s_q;
    s_d.fs_prev = frame_sync;
    s_d.conversion_clock_prev = conversion_clock;

    // bus: ready rises one cycle into the access phase
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = psel && penable && !s_q.pready && !mapped;
    if (psel && penable && !s_q.pready) begin
      s_d.prdata = '0;
      if (!pwrite) begin
        if (is_dep) begin
          s_d.prdata = {16'h0000, dep_rdata}; // RULE_19
        end else if (index == IDX_ADC_FORMAT) begin
          s_d.prdata = {16'h0000, s_q.format};
        end else if (index == IDX_POWER) begin
          s_d.prdata = {16'h0000, s_q.power};
        end
      end
    end

    // software writes; reserved bits are stored as zero
    if (wr_fire && index == IDX_POWER) begin
      s_d.power = wdata16 & POWER_MASK; // RULE_05
    end
    if (wr_fire && index == IDX_ADC_FORMAT) begin
      s_d.format = wdata16 & FORMAT_MASK; // RULE_01 RULE_02
    end

    // freeze at defaults while pins or converter status demand it
    if (hold_power) begin
      s_d.power = POWER_RESET; // RULE_17
    end
    if (hold_format) begin
      s_d.format = FORMAT_RESET; // RULE_04
    end

    // analog paths follow their own bits only under analog enable
    s_d.ana = en_ana;
    s_d.dac1_ana = en_ana && en_dac1; // RULE_13
    s_d.dac2_ana = en_ana && en_dac2; // RULE_13
    s_d.adcl_ana = en_ana && en_adcl; // RULE_13
    s_d.adcr_ana = en_ana && en_adcr; // RULE_13
    s_d.ddm = en_ana && en_ddm; // RULE_07 RULE_13
    s_d.aam = en_ana && en_aam; // RULE_15 RULE_13
    s_d.hp = s_q.power[BIT_HEADPHONE]; // RULE_14
    s_d.rfree = s_q.power[BIT_RESOURCE_FREE];

    // digital resources stay alive when lent to enabled channels
    s_d.dig = chan_enable | {NUM_CH{s_q.power[BIT_RESOURCE_FREE]}}; // RULE_06
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // async reset to documented defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.power <= POWER_RESET; // RULE_17
      s_q.format <= FORMAT_RESET; // RULE_04
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // bus answer
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

  // power controls
  assign resource_free = s_q.rfree;
  assign analog_power = s_q.ana;
  assign dac_one_analog_power = s_q.dac1_ana;
  assign dac_two_analog_power = s_q.dac2_ana;
  assign adc_left_analog_power = s_q.adcl_ana;
  assign adc_right_analog_power = s_q.adcr_ana;
  assign dac_to_dac_mix_power = s_q.ddm;
  assign analog_mix_power = s_q.aam;
  assign headphone_power = s_q.hp;
  assign digital_power = s_q.dig;

  // sequencer outputs come from flops inside the sequencers
  assign sample_request = chan_req;
  assign conversion_running = chan_run;

  // sample formats
  assign adc_left_format = s_q.format[FMT_LEFT_LSB +: 2]; // RULE_02
  assign adc_right_format = s_q.format[FMT_RIGHT_LSB +: 2]; // RULE_01

endmodule : codec_power_ctrl

// file: core/codec_power_pkg.sv
package codec_power_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_SHIFT = 2;
  localparam logic [5:0] IDX_DEP_FIRST = 6'h03;
  localparam logic [5:0] IDX_DEP_LAST = 6'h0a;
  localparam logic [5:0] IDX_MIX_DAC = 6'h03;
  localparam logic [5:0] IDX_ANA_FIRST = 6'h04;
  localparam logic [5:0] IDX_ANA_LAST = 6'h07;
  localparam logic [5:0] IDX_HALF = 6'h08;
  localparam logic [5:0] IDX_DAC1_LEVEL = 6'h09;
  localparam logic [5:0] IDX_DAC2_LEVEL = 6'h0a;
  localparam logic [5:0] IDX_ADC_FORMAT = 6'h1a;
  localparam logic [5:0] IDX_POWER = 6'h1b;

  // ----------------------------------------------------------------
  // channel power-down fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RESOURCE_FREE = 15;
  localparam int unsigned BIT_DAC_MIX = 12;
  localparam int unsigned BIT_DAC_TWO = 9;
  localparam int unsigned BIT_DAC_ONE = 8;
  localparam int unsigned BIT_ANALOG = 7;
  localparam int unsigned BIT_HEADPHONE = 6;
  localparam int unsigned BIT_ANALOG_MIX = 4;
  localparam int unsigned BIT_ADC_RIGHT = 1;
  localparam int unsigned BIT_ADC_LEFT = 0;
  localparam logic [15:0] POWER_RESET = 16'h00c0;
  localparam logic [15:0] POWER_MASK = 16'h93d3;
  localparam logic [15:0] HALF_MASK = 16'h00ff;

  // ----------------------------------------------------------------
  // adc sample format fields and encodings
  // ----------------------------------------------------------------
  localparam int unsigned FMT_RIGHT_LSB = 0;
  localparam int unsigned FMT_LEFT_LSB = 8;
  localparam logic [15:0] FORMAT_RESET = 16'h0000;
  localparam logic [15:0] FORMAT_MASK = 16'h0303;
  localparam logic [1:0] FMT_UNSIGNED8 = 2'h0;
  localparam logic [1:0] FMT_SIGNED16 = 2'h1;
  localparam logic [1:0] FMT_MULAW8 = 2'h2;
  localparam logic [1:0] FMT_ALAW8 = 2'h3;

  // ----------------------------------------------------------------
  // channels and startup timing
  // ----------------------------------------------------------------
  localparam int unsigned CH_DAC_ONE = 0;
  localparam int unsigned CH_DAC_TWO = 1;
  localparam int unsigned CH_ADC_LEFT = 2;
  localparam int unsigned CH_ADC_RIGHT = 3;
  localparam int unsigned NUM_CH = 4;
  localparam logic [2:0] START_FS_EDGES = 3'h6;
  localparam logic [15:0] DEP_DEFAULT = 16'h0000;

endpackage : codec_power_pkg

// file: core/channel_start.sv
`timescale 1ns/1ns
module channel_start
  import codec_power_pkg::*;
#(
  parameter bit IS_ADC = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic fs_rise,
  input wire logic conversion_clock_rise,
  output logic request,
  output logic running
);

  typedef struct packed {
    logic req;
    logic run;
    logic armed;
    logic prev_en;
    logic [2:0] fs_cnt;
  } chan_state_type;

  chan_state_type s_q, s_d;

  // start counts six frame-sync edges, then waits for a conversion edge
  always_comb begin
    s_d = s_q;
    s_d.prev_en = enable;
    if (!enable) begin
      s_d.run = 1'b0;
      s_d.armed = 1'b0;
      s_d.fs_cnt = '0;
      if (!IS_ADC || fs_rise) begin
        s_d.req = 1'b0; // RULE_08 RULE_10 RULE_16
      end
    end else begin
      if (!s_q.prev_en) begin
        s_d.armed = 1'b1;
        s_d.fs_cnt = '0;
      end else if (s_q.armed) begin
        if (s_q.fs_cnt == START_FS_EDGES && conversion_clock_rise) begin
          s_d.run = 1'b1; // RULE_09 RULE_11 RULE_16
          s_d.armed = 1'b0;
        end else if (fs_rise && s_q.fs_cnt != START_FS_EDGES) begin
          s_d.fs_cnt = s_q.fs_cnt + 3'h1;
        end
      end
      if (!IS_ADC && fs_rise) begin
        s_d.req = 1'b1; // RULE_09 RULE_11
      end
      if (IS_ADC && s_d.run) begin
        s_d.req = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign request = s_q.req;
  assign running = s_q.run;

endmodule : channel_start

// file: core/dependent_regs.sv
`timescale 1ns/1ns
module dependent_regs
  import codec_power_pkg::*;
#(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_index,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  input wire logic [DEPTH-1:0][WIDTH-1:0] hold_mask,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [WIDTH-1:0] rdata;
  } mem_state_type;

  mem_state_type s_q, s_d;

  // held bits stay at default and drop writes; read data registered
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < DEPTH; i++) begin
      if (wr_en && wr_index == i[$clog2(DEPTH)-1:0]) begin
        s_d.words[i] = wr_data;
      end
      s_d.words[i] = (s_d.words[i] & ~hold_mask[i]) |
                     (DEP_DEFAULT[WIDTH-1:0] & hold_mask[i]); // RULE_19
    end
    s_d.rdata = s_q.words[rd_index];
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;

endmodule : dependent_regs

// file: dv/tdm_host_model.sv
`timescale 1ns/1ns
module tdm_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] fs_period,
  output logic frame_sync,
  output logic conversion_clock
);
  logic [7:0] fs_cnt_q;
  logic [2:0] cv_cnt_q;

  // frame counter wraps at the chosen frame length, conversion clock runs free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_cnt_q <= 8'h00;
      cv_cnt_q <= 3'h0;
    end else begin
      fs_cnt_q <= (fs_cnt_q >= fs_period - 8'h01) ? 8'h00 : fs_cnt_q + 8'h01;
      cv_cnt_q <= cv_cnt_q + 3'h1;
    end
  end

  // sync is high for two cycles at the start of each frame
  assign frame_sync = (fs_cnt_q < 8'h02) && !rst;
  assign conversion_clock = cv_cnt_q[2];
endmodule : tdm_host_model

// file: dv/codec_power_ctrl_checker.sv
`timescale 1ns/1ns
module codec_power_ctrl_checker
  import codec_power_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reset_pin_n,
  input wire logic power_down_pin_n,
  input wire logic converter_power_status,
  input wire logic conversion_clock,
  input wire logic resource_free,
  input wire logic analog_power,
  input wire logic dac_one_analog_power,
  input wire logic dac_two_analog_power,
  input wire logic adc_left_analog_power,
  input wire logic adc_right_analog_power,
  input wire logic dac_to_dac_mix_power,
  input wire logic analog_mix_power,
  input wire logic headphone_power,
  input wire logic [NUM_CH-1:0] digital_power,
  input wire logic [NUM_CH-1:0] sample_request,
  input wire logic [NUM_CH-1:0] conversion_running,
  input wire logic [1:0] adc_left_format,
  input wire logic [1:0] adc_right_format
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_time: assert property (s_setup ##1 s_access |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_error_ready: assert property (pslverr |-> pready) else $error("error without ready");

  // ------------------------------------------------------------
  // power outputs
  // ------------------------------------------------------------
  a_analog_gate: assert property (!analog_power |-> !(dac_one_analog_power ||
    dac_two_analog_power || adc_left_analog_power || adc_right_analog_power ||
    dac_to_dac_mix_power || analog_mix_power)) else $error("path on with analog off");
  a_lend_digital: assert property (resource_free |-> digital_power == 4'hf)
    else $error("digital not lent");
  a_dac_one_stop: assert property (!resource_free && !digital_power[0] |->
    !sample_request[0]) else $error("dac one still requests");
  a_dac_two_stop: assert property (!resource_free && !digital_power[1] |->
    !sample_request[1]) else $error("dac two still requests");

  // ------------------------------------------------------------
  // channel start on conversion clock rise
  // ------------------------------------------------------------
  property p_conversion_clock_start(int ch);
    $rose(conversion_running[ch]) |-> $past(conversion_clock) && !$past(conversion_clock, 2);
  endproperty
  a_start_one: assert property (p_conversion_clock_start(0)) else $error("dac one start off clock");
  a_start_two: assert property (p_conversion_clock_start(1)) else $error("dac two start off clock");
  a_start_adc: assert property (p_conversion_clock_start(2)) else $error("adc start off clock");
  a_adc_req_run: assert property ($rose(sample_request[3]) |-> conversion_running[3])
    else $error("adc request before run");

  // ------------------------------------------------------------
  // pins and converter status force defaults
  // ------------------------------------------------------------
  a_pin_clear: assert property (!reset_pin_n [*4] |-> analog_power && headphone_power &&
    !resource_free && digital_power == 4'h0) else $error("power not default");
  a_status_clear: assert property (converter_power_status [*4] |->
    !dac_one_analog_power && !analog_mix_power) else $error("power not default");
  a_format_hold: assert property (!power_down_pin_n [*4] |->
    adc_left_format == FMT_UNSIGNED8 && adc_right_format == FMT_UNSIGNED8)
    else $error("format not default");
endmodule : codec_power_ctrl_checker

// file: dv/codec_power_ctrl_test.sv
`timescale 1ns/1ns
module codec_power_ctrl_test
  import codec_power_pkg::*;
;
  typedef struct {logic [31:0] d; logic e; bit rd;} note_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] pwdata = 32'h0, prdata;
  logic reset_pin_n = 1'b1, power_down_pin_n = 1'b1, converter_power_status = 1'b0;
  logic frame_sync, conversion_clock, fs_last = 1'b0;
  logic [7:0] fs_period = 8'h2c;
  logic resource_free, analog_power, dac_one_analog_power, dac_two_analog_power;
  logic adc_left_analog_power, adc_right_analog_power, dac_to_dac_mix_power;
  logic analog_mix_power, headphone_power;
  logic [3:0] digital_power, sample_request, conversion_running;
  logic [1:0] adc_left_format, adc_right_format;
  logic [15:0] v, keep [5];
  logic [5:0] dep [5] = '{IDX_MIX_DAC, IDX_ANA_FIRST, IDX_HALF, IDX_DAC1_LEVEL, IDX_DAC2_LEVEL};
  int n_fail = 0, checks = 0, cycles = 0, fs_rises = 0, seed = 32'h9908;
  note_type exp_q [$], nt;

  always #4 clk = ~clk;

  codec_power_ctrl dut_u (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .reset_pin_n, .power_down_pin_n, .converter_power_status,
    .frame_sync, .conversion_clock, .resource_free, .analog_power, .dac_one_analog_power,
    .dac_two_analog_power, .adc_left_analog_power, .adc_right_analog_power,
    .dac_to_dac_mix_power, .analog_mix_power, .headphone_power, .digital_power,
    .sample_request, .conversion_running, .adc_left_format, .adc_right_format);
  tdm_host_model host_u (.clk, .rst, .fs_period, .frame_sync, .conversion_clock);

  // ------------------------------------------------------------
  // compare, report and bus tasks
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  function automatic logic [7:0] pa(input logic [5:0] i);
    return {i, 2'b00};
  endfunction : pa

  // one bus transfer, held until ready is seen at an edge
  task xfer(input logic [7:0] a, input logic w, input logic [15:0] d, input logic e);
    exp_q.push_back('{32'(d), e, !w});
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= 32'(d);
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle limit here: only the bench timeout ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // power outputs against a power register value
  task outs(input logic [15:0] p);
    repeat (3) @(posedge clk);
    check(32'({resource_free, analog_power, headphone_power, dac_one_analog_power,
      dac_two_analog_power, adc_left_analog_power, adc_right_analog_power,
      dac_to_dac_mix_power, analog_mix_power}), 32'({p[15], p[7], p[6],
      {6{p[7]}} & {p[8], p[9], p[0], p[1], p[12], p[4]}}));
    check(32'(digital_power), 32'({p[1], p[0], p[9], p[8]} | {4{p[15]}}));
  endtask : outs

  // enable all channels, count frame syncs to start, then power some down
  task start_test(input logic [7:0] per);
    int k;
    fs_period <= per;
    xfer(pa(IDX_POWER), 1'b1, POWER_RESET, 1'b0);
    xfer(pa(IDX_POWER), 1'b1, 16'h03c3, 1'b0);
    fs_rises = 0;
    k = 0;
    while (conversion_running !== 4'hf && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check(32'(conversion_running), 32'hf);
    check(32'(fs_rises >= 6 && fs_rises <= 7), 32'h1);
    check(32'(sample_request), 32'hf);
    xfer(pa(IDX_POWER), 1'b1, 16'h01c0, 1'b0);
    repeat (2) @(posedge clk);
    check(32'(sample_request[1]), 32'h0);
    check(32'(conversion_running[3:2]), 32'h0);
    repeat (int'(per) + 4) @(posedge clk);
    check(32'(sample_request[3:2]), 32'h0);
    $display("start test done");
  endtask : start_test

  // ------------------------------------------------------------
  // result monitor, frame sync counter and timeout
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      check(32'(pslverr), 32'(nt.e));
      if (nt.rd) check(prdata, nt.d);
    end
  end

  always @(posedge clk) begin
    fs_last <= frame_sync;
    if (frame_sync === 1'b1 && fs_last === 1'b0) fs_rises++;
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    xfer(pa(IDX_POWER), 1'b0, POWER_RESET, 1'b0);
    xfer(pa(IDX_ADC_FORMAT), 1'b0, FORMAT_RESET, 1'b0);
    outs(POWER_RESET);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      v = {6'h0, 2'(3 - i), 6'h0, 2'(i)};
      xfer(pa(IDX_ADC_FORMAT), 1'b1, v, 1'b0);
      xfer(pa(IDX_ADC_FORMAT), 1'b0, v, 1'b0);
      check(32'(adc_right_format), 32'(i));
      check(32'(adc_left_format), 32'(3 - i));
    end
    $display("format test done");
    for (int i = 0; i < 5; i++) begin
      v = 16'($random(seed));
      xfer(pa(dep[i]), 1'b1, v, 1'b0);
      xfer(pa(dep[i]), 1'b0, (dep[i] == IDX_HALF) ? v & ~HALF_MASK : DEP_DEFAULT, 1'b0);
    end
    xfer(pa(IDX_POWER), 1'b1, POWER_MASK, 1'b0);
    outs(POWER_MASK);
    for (int i = 0; i < 5; i++) begin
      keep[i] = 16'($random(seed));
      xfer(pa(dep[i]), 1'b1, keep[i], 1'b0);
      xfer(pa(dep[i]), 1'b0, keep[i], 1'b0);
    end
    xfer(pa(IDX_POWER), 1'b1, POWER_MASK & ~16'h0080, 1'b0);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? keep[0] : (i == 2) ? keep[2] & ~HALF_MASK : DEP_DEFAULT;
      xfer(pa(dep[i]), 1'b0, v, 1'b0);
    end
    xfer(8'h80, 1'b1, 16'hffff, 1'b1);
    xfer(8'h80, 1'b0, 16'h0000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed)) & POWER_MASK;
      v[1] = v[0];
      xfer(pa(IDX_POWER), 1'b1, v, 1'b0);
      xfer(pa(IDX_POWER), 1'b0, v, 1'b0);
      outs(v);
    end
    $display("register test done");
    start_test(8'h2c);
    start_test(8'h64);
    xfer(pa(IDX_ADC_FORMAT), 1'b1, 16'h0303, 1'b0);
    reset_pin_n <= 1'b0;
    xfer(pa(IDX_POWER), 1'b1, 16'h0383, 1'b0);
    reset_pin_n <= 1'b1;
    xfer(pa(IDX_POWER), 1'b0, POWER_RESET, 1'b0);
    xfer(pa(IDX_ADC_FORMAT), 1'b0, FORMAT_RESET, 1'b0);
    power_down_pin_n <= 1'b0;
    xfer(pa(IDX_ADC_FORMAT), 1'b1, 16'h0303, 1'b0);
    power_down_pin_n <= 1'b1;
    xfer(pa(IDX_ADC_FORMAT), 1'b0, FORMAT_RESET, 1'b0);
    converter_power_status <= 1'b1;
    xfer(pa(IDX_POWER), 1'b1, 16'h0383, 1'b0);
    converter_power_status <= 1'b0;
    xfer(pa(IDX_POWER), 1'b0, POWER_RESET, 1'b0);
    $display("pin test done");
    final_report();
  end
endmodule : codec_power_ctrl_test

bind codec_power_ctrl codec_power_ctrl_checker chk_u (.clk, .rst, .psel, .penable, .pready,
  .pslverr, .reset_pin_n, .power_down_pin_n, .converter_power_status, .conversion_clock,
  .resource_free, .analog_power, .dac_one_analog_power, .dac_two_analog_power,
  .adc_left_analog_power, .adc_right_analog_power, .dac_to_dac_mix_power,
  .analog_mix_power, .headphone_power, .digital_power, .sample_request,
  .conversion_running, .adc_left_format, .adc_right_format);
